// file: include/twd_pkg.sv
// shared constants, field layouts and types of the timer watchdog block
package twd_pkg;

    // time base geometry
    localparam int unsigned TB_W       = 64;
    localparam int unsigned WORD_W     = 32;
    localparam logic [63:0] TB_RESET   = 64'h0000_0000_0000_0000;

    // watchdog candidate bits, lsb-0 index into the 64-bit time base
    // period 2^(n+1) clocks means bit n rises once every 2^(n+1) ticks
    localparam int unsigned WD_BIT_P0  = 20;  // low word bit 11, 2^21
    localparam int unsigned WD_BIT_P1  = 24;  // low word bit 7, 2^25
    localparam int unsigned WD_BIT_P2  = 28;  // low word bit 3, 2^29
    localparam int unsigned WD_BIT_P3  = 32;  // high word bit 31, 2^33

    // interval candidate bits, lsb-0 index into the time base
    localparam int unsigned IV_BIT_P0  = 12;  // low word bit 19, 2^13
    localparam int unsigned IV_BIT_P1  = 16;  // low word bit 15, 2^17
    localparam int unsigned IV_BIT_P2  = 20;  // low word bit 11, 2^21
    localparam int unsigned IV_BIT_P3  = 24;  // low word bit 7, 2^25

    // reset kind encodings
    localparam logic [1:0] KIND_NONE   = 2'h0;
    localparam logic [1:0] KIND_CORE   = 2'h1;
    localparam logic [1:0] KIND_CHIP   = 2'h2;
    localparam logic [1:0] KIND_SYSTEM = 2'h3;

    // register reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] STAT_RESET = 32'h0000_0000;

    // writable field mask of the control word, msb-0 bits 0:9
    localparam logic [31:0] CTRL_WMASK = 32'hffc0_0000;
    // implemented bits of the status word, msb-0 bits 0:5
    localparam logic [31:0] STAT_MASK  = 32'hfc00_0000;

    // control word, first member is msb-0 bit 0 (lsb-0 bit 31)
    typedef struct packed {
        logic [1:0]  wd_period;             // watchdog period select
        logic [1:0]  watchdog_reset_kind;   // sticky, set-only by software
        logic        watchdog_irq_enable;
        logic        countdown_irq_enable;
        logic [1:0]  interval_period_select;
        logic        interval_irq_enable;
        logic        auto_reload;
        logic [21:0] rsvd;
    } twd_ctrl_t;

    // status word, first member is msb-0 bit 0
    typedef struct packed {
        logic        arm_next_watchdog;
        logic        watchdog_irq_status;
        logic [1:0]  last_watchdog_reset_kind;
        logic        countdown_event_flag;
        logic        interval_event_flag;
        logic [25:0] rsvd;
    } twd_stat_t;

    // reset request toward the reset sequencer
    typedef struct packed {
        logic        req;
        logic [1:0]  kind;
    } twd_rst_t;

    // special-register selector for moves to and from the block
    typedef enum logic [1:0] {
        SPR_CTRL,
        SPR_STAT,
        SPR_TB_LOW,
        SPR_TB_HIGH
    } twd_spr_t;

    // action taken on one watchdog exception
    typedef enum logic [1:0] {
        ACT_NONE,
        ACT_ARM,
        ACT_FLAG,
        ACT_RESET
    } twd_action_t;

endpackage

// file: verilog/twd_bit_rise.sv
// rising-edge detector on one of four selectable time base bits
`timescale 1ns/10ps
module twd_bit_rise
    import twd_pkg::*;
#(
    parameter int unsigned P0 = 0,
    parameter int unsigned P1 = 1,
    parameter int unsigned P2 = 2,
    parameter int unsigned P3 = 3
) (
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            sys_rst,
    // observed counter and selection
    input  wire logic [TB_W-1:0] tb,
    input  wire logic [1:0]      sel,
    // one-cycle pulse on a 0 to 1 change of the selected bit
    output wire logic            rise
);

    logic [3:0] cand;
    logic [3:0] prev;

    // all four candidates are tracked, so a change of sel never fakes an edge
    assign cand = {tb[P3], tb[P2], tb[P1], tb[P0]};

    // any cause of the change counts, a software write just as a tick
    assign rise = cand[sel] & ~prev[sel];

    // previous value of every candidate bit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prev <= 4'h0;
        end else begin
            prev <= cand;
        end
    end

endmodule

// file: verilog/twd_top.sv
// timer watchdog control: time base, control and status words, watchdog
`timescale 1ns/10ps
module twd_top
    import twd_pkg::*;
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // special-register moves
    input  wire logic             spr_wr_en,
    input  wire twd_spr_t         spr_wr_sel,
    input  wire logic [31:0]      spr_wr_data,
    input  wire twd_spr_t         spr_rd_sel,
    output logic      [31:0]      spr_rd_data,
    // timer clock source
    input  wire logic             timer_clock_pick,
    input  wire logic             ext_timer_clk,
    // debug freeze
    input  wire logic             freeze_enable,
    input  wire logic             debug_event_recorded,
    // countdown timer side
    input  wire logic             countdown_event,
    output logic                  countdown_tick,
    output twd_ctrl_t             ctrl_out,
    // time base view
    output logic      [TB_W-1:0]  time_base,
    // requests toward the core
    output logic                  watchdog_irq,
    output logic                  countdown_irq,
    output logic                  interval_irq,
    output twd_rst_t              wd_reset
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    twd_ctrl_t   ctrl;
    twd_stat_t   stat;
    logic        ext_sample;
    logic        ext_prev;

    twd_ctrl_t   next_ctrl;
    twd_stat_t   next_stat;
    twd_rst_t    next_wd_reset;
    logic [TB_W-1:0] next_time_base;
    logic [31:0] next_rd_data;

    // ------------------------------------------------------------------
    // timer clock source and freeze
    // ------------------------------------------------------------------
    logic ext_rise;
    logic src_tick;
    logic frozen;
    logic tb_tick;

    // external source is sampled once, so it can tick at most every
    // second clock; a faster input simply loses edges
    assign ext_rise = ext_sample & ~ext_prev;
    assign src_tick = timer_clock_pick ? ext_rise : 1'b1;

    // freeze holds while the debug event stays recorded
    assign frozen  = freeze_enable & debug_event_recorded;
    assign tb_tick = src_tick & ~frozen;

    // sample latch and its delayed copy for the edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ext_sample <= 1'b0;
            ext_prev   <= 1'b0;
        end else begin
            ext_sample <= ext_timer_clk;
            ext_prev   <= ext_sample;
        end
    end

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    logic wr_ctrl;
    logic wr_stat;
    logic wr_tb_low;
    logic wr_tb_high;

    assign wr_ctrl    = spr_wr_en & (spr_wr_sel == SPR_CTRL);
    assign wr_stat    = spr_wr_en & (spr_wr_sel == SPR_STAT);
    assign wr_tb_low  = spr_wr_en & (spr_wr_sel == SPR_TB_LOW);
    assign wr_tb_high = spr_wr_en & (spr_wr_sel == SPR_TB_HIGH);

    // ------------------------------------------------------------------
    // time base
    // ------------------------------------------------------------------
    // a write replaces its half and drops the tick of that cycle
    assign next_time_base =
        wr_tb_low  ? {time_base[63:32], spr_wr_data} :
        wr_tb_high ? {spr_wr_data, time_base[31:0]} :
        tb_tick    ? time_base + 64'h1 :
                     time_base;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            time_base <= TB_RESET;
        end else begin
            time_base <= next_time_base;
        end
    end

    // ------------------------------------------------------------------
    // exception detection on selected time base bits
    // ------------------------------------------------------------------
    logic wd_exc;
    logic iv_exc;

    // watchdog bit choice follows the period select field
    twd_bit_rise #(
        .P0 (WD_BIT_P0),
        .P1 (WD_BIT_P1),
        .P2 (WD_BIT_P2),
        .P3 (WD_BIT_P3)
    ) u_wd_rise (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tb      (time_base),
        .sel     (ctrl.wd_period),
        .rise    (wd_exc)
    );

    // interval timer shares the same edge logic
    twd_bit_rise #(
        .P0 (IV_BIT_P0),
        .P1 (IV_BIT_P1),
        .P2 (IV_BIT_P2),
        .P3 (IV_BIT_P3)
    ) u_iv_rise (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tb      (time_base),
        .sel     (ctrl.interval_period_select),
        .rise    (iv_exc)
    );

    // ------------------------------------------------------------------
    // watchdog action decode
    // ------------------------------------------------------------------
    twd_action_t action;

    // the action depends on the flags as they stand before this cycle
    always_comb begin
        action = ACT_NONE;
        if (wd_exc) begin
            case ({stat.arm_next_watchdog, stat.watchdog_irq_status})
                2'h0:    action = ACT_ARM;
                2'h1:    action = ACT_ARM;
                2'h2:    action = ACT_FLAG;
                2'h3:    action = ACT_RESET;
                default: action = ACT_NONE;
            endcase
        end
    end

    logic set_arm;
    logic set_flag;
    logic fire_reset;

    assign set_arm    = (action == ACT_ARM);
    assign set_flag   = (action == ACT_FLAG);
    // with no reset kind chosen the third step does nothing at all
    assign fire_reset = (action == ACT_RESET) &
                        (ctrl.watchdog_reset_kind != KIND_NONE);

    // ------------------------------------------------------------------
    // control word
    // ------------------------------------------------------------------
    twd_ctrl_t wr_ctrl_word;
    logic [1:0] next_kind;

    assign wr_ctrl_word = twd_ctrl_t'(spr_wr_data & CTRL_WMASK);

    // kind bits only ever go up by software; the reset path empties them,
    // which keeps errant code from disarming the watchdog reset
    assign next_kind =
        fire_reset ? KIND_NONE :
        wr_ctrl    ? (ctrl.watchdog_reset_kind |
                      wr_ctrl_word.watchdog_reset_kind) :
                     ctrl.watchdog_reset_kind;

    always_comb begin
        next_ctrl = ctrl;
        if (wr_ctrl) begin
            next_ctrl = wr_ctrl_word;
        end
        next_ctrl.watchdog_reset_kind = next_kind;
        next_ctrl.rsvd = 22'h0;
    end

    // processor reset clears all, auto-reload among it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl <= twd_ctrl_t'(CTRL_RESET);
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ------------------------------------------------------------------
    // status word
    // ------------------------------------------------------------------
    twd_stat_t clr;

    // software write is a clear mask, never data
    assign clr = wr_stat ? twd_stat_t'(spr_wr_data & STAT_MASK)
                         : twd_stat_t'(32'h0);

    // a hardware set in the same cycle as its clear wins
    always_comb begin
        next_stat = stat;
        next_stat.arm_next_watchdog =
            (stat.arm_next_watchdog & ~clr.arm_next_watchdog) |
            set_arm;
        next_stat.watchdog_irq_status =
            (stat.watchdog_irq_status & ~clr.watchdog_irq_status) |
            set_flag;
        next_stat.last_watchdog_reset_kind =
            fire_reset ? ctrl.watchdog_reset_kind :
            (stat.last_watchdog_reset_kind &
             ~clr.last_watchdog_reset_kind);
        next_stat.countdown_event_flag =
            (stat.countdown_event_flag & ~clr.countdown_event_flag) |
            countdown_event;
        next_stat.interval_event_flag =
            (stat.interval_event_flag & ~clr.interval_event_flag) |
            iv_exc;
        next_stat.rsvd = 26'h0;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stat <= twd_stat_t'(STAT_RESET);
        end else begin
            stat <= next_stat;
        end
    end

    // ------------------------------------------------------------------
    // requests toward the core
    // ------------------------------------------------------------------
    logic next_wd_irq;
    logic next_cd_irq;
    logic next_iv_irq;

    // levels from the updated flags; the core applies its critical or
    // external enable, so a handler must drop status or enable itself
    assign next_wd_irq = next_stat.watchdog_irq_status &
                         next_ctrl.watchdog_irq_enable;
    assign next_cd_irq = next_stat.countdown_event_flag &
                         next_ctrl.countdown_irq_enable;
    assign next_iv_irq = next_stat.interval_event_flag &
                         next_ctrl.interval_irq_enable;

    // reset request lives for one cycle only
    assign next_wd_reset.req  = fire_reset;
    assign next_wd_reset.kind = fire_reset ? ctrl.watchdog_reset_kind
                                           : KIND_NONE;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            watchdog_irq  <= 1'b0;
            countdown_irq <= 1'b0;
            interval_irq  <= 1'b0;
            wd_reset      <= '0;
        end else begin
            watchdog_irq  <= next_wd_irq;
            countdown_irq <= next_cd_irq;
            interval_irq  <= next_iv_irq;
            wd_reset      <= next_wd_reset;
        end
    end

    // ------------------------------------------------------------------
    // countdown side outputs
    // ------------------------------------------------------------------
    // tick is registered, so the countdown timer runs one cycle behind
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            countdown_tick <= 1'b0;
            ctrl_out       <= twd_ctrl_t'(CTRL_RESET);
        end else begin
            countdown_tick <= tb_tick;
            ctrl_out       <= next_ctrl;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // registered read data, one cycle after the selector
    assign next_rd_data =
        (spr_rd_sel == SPR_CTRL)   ? 32'(ctrl) :
        (spr_rd_sel == SPR_STAT)   ? 32'(stat) :
        (spr_rd_sel == SPR_TB_LOW) ? time_base[31:0] :
                                     time_base[63:32];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            spr_rd_data <= 32'h0;
        end else begin
            spr_rd_data <= next_rd_data;
        end
    end

endmodule

// file: verification/twd_top_asserts.sv
// port assertions of the timer watchdog top
`timescale 1ns/10ps
module twd_top_asserts
    import twd_pkg::*;
(
    // clock and reset
    input wire logic            clk_sys,
    input wire logic            sys_rst,
    // register moves
    input wire logic            spr_wr_en,
    input wire twd_spr_t        spr_wr_sel,
    input wire logic [31:0]     spr_wr_data,
    input wire twd_spr_t        spr_rd_sel,
    input wire logic [31:0]     spr_rd_data,
    // clock source, freeze, countdown side
    input wire logic            timer_clock_pick,
    input wire logic            ext_timer_clk,
    input wire logic            freeze_enable,
    input wire logic            debug_event_recorded,
    input wire logic            countdown_event,
    input wire logic            countdown_tick,
    input wire twd_ctrl_t       ctrl_out,
    // time base and requests
    input wire logic [TB_W-1:0] time_base,
    input wire logic            watchdog_irq,
    input wire logic            countdown_irq,
    input wire logic            interval_irq,
    input wire twd_rst_t        wd_reset
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // watched bit and quiet spells of the time base
    wire logic sel_bit = time_base[WD_BIT_P0 + 4 * ctrl_out.wd_period];
    wire logic quiet   = !timer_clock_pick && !spr_wr_en
                         && !(freeze_enable && debug_event_recorded);
    wire logic frozen  = freeze_enable && debug_event_recorded && !spr_wr_en;

    // exception seen one or two cycles back, latency left open
    sequence s_exc;
        $past(sel_bit) && (!$past(sel_bit, 2) || !$past(sel_bit, 3));
    endsequence
    // a firing carries a real kind and leaves the control kind empty
    sequence s_fire;
        wd_reset.kind != KIND_NONE
            && ctrl_out.watchdog_reset_kind == KIND_NONE;
    endsequence

    a_irq_needs_enable: assert property (
        watchdog_irq |-> ctrl_out.watchdog_irq_enable)
        else $error("watchdog irq without its enable");
    a_irq_after_exc: assert property (
        $rose(watchdog_irq) && $past(ctrl_out.watchdog_irq_enable) |-> s_exc)
        else $error("watchdog irq without a bit rise");
    a_reset_after_exc: assert property (
        wd_reset.req |-> s_exc)
        else $error("reset request without a bit rise");
    a_reset_fire_kind: assert property (
        wd_reset.req |-> s_fire)
        else $error("reset fired with bad kind handling");
    a_kind_copied: assert property (
        wd_reset.req |-> wd_reset.kind == $past(ctrl_out.watchdog_reset_kind))
        else $error("reset kind differs from control kind");
    a_reset_one_cycle: assert property (
        wd_reset.req |=> !wd_reset.req)
        else $error("reset request longer than one cycle");
    a_kind_sticky: assert property (
        !wd_reset.req |-> (ctrl_out.watchdog_reset_kind
            & $past(ctrl_out.watchdog_reset_kind))
            == $past(ctrl_out.watchdog_reset_kind))
        else $error("reset kind bit cleared by software");
    a_rsvd_zero: assert property (
        ctrl_out.rsvd == 22'h0)
        else $error("reserved control bits not zero");
    a_tb_counts: assert property (
        quiet ##1 quiet |=> time_base == $past(time_base) + 64'h1)
        else $error("time base missed a tick");
    a_tb_frozen: assert property (
        frozen [*2] |=> $stable(time_base))
        else $error("time base moved while frozen");
endmodule
bind twd_top twd_top_asserts u_twd_top_asserts (
    .clk_sys, .sys_rst, .spr_wr_en, .spr_wr_sel, .spr_wr_data, .spr_rd_sel,
    .spr_rd_data, .timer_clock_pick, .ext_timer_clk, .freeze_enable,
    .debug_event_recorded, .countdown_event, .countdown_tick, .ctrl_out,
    .time_base, .watchdog_irq, .countdown_irq, .interval_irq, .wd_reset
);

// file: verification/twd_core_model.sv
// core side model: critical interrupt gate and reset sequencer
`timescale 1ns/10ps
module twd_core_model
    import twd_pkg::*;
(
    // clock and reset
    input  wire logic     clk_sys,
    input  wire logic     sys_rst,
    // requests from the watchdog
    input  wire logic     watchdog_irq,
    input  wire twd_rst_t wd_reset,
    // software restores the critical enable
    input  wire logic     crit_restore,
    // observations
    output logic [7:0]    crit_cnt,
    output logic [7:0]    resets_seen,
    output logic [1:0]    last_kind
);
    logic crit_en;

    // taking a critical interrupt masks more until software restores it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            crit_en     <= 1'b1;
            crit_cnt    <= 8'h0;
            resets_seen <= 8'h0;
            last_kind   <= 2'h0;
        end else begin
            if (watchdog_irq && crit_en) begin
                crit_en  <= 1'b0;
                crit_cnt <= crit_cnt + 8'h1;
            end else if (crit_restore) begin
                crit_en <= 1'b1;
            end
            if (wd_reset.req) begin
                resets_seen <= resets_seen + 8'h1;
                last_kind   <= wd_reset.kind;
            end
        end
    end
endmodule

// file: verification/twd_top_tb.sv
// self-checking bench for the timer watchdog top
`timescale 1ns/10ps
module twd_top_tb
    import twd_pkg::*;
;
    logic            clk_sys = 1'b0, sys_rst = 1'b1, spr_wr_en = 1'b0;
    twd_spr_t        spr_wr_sel = SPR_CTRL, spr_rd_sel = SPR_CTRL;
    logic [31:0]     spr_wr_data = 32'h0, spr_rd_data, r;
    logic            timer_clock_pick = 1'b0, ext_timer_clk = 1'b0;
    logic            freeze_enable = 1'b0, debug_event_recorded = 1'b0;
    logic            countdown_event = 1'b0, crit_restore = 1'b0;
    logic            countdown_tick, watchdog_irq, countdown_irq;
    logic            interval_irq, rd_pend = 1'b0, rd_due = 1'b0;
    twd_ctrl_t       ctrl_out;
    logic [TB_W-1:0] time_base;
    twd_rst_t        wd_reset;
    logic [7:0]      crit_cnt, resets_seen;
    logic [1:0]      last_kind;
    logic [31:0]     eq[$], mq[$];
    logic [1:0]      kq[$];
    int              error_cnt = 0, n_checks = 0, nrise = 0, seed_dummy;

    twd_top u_twd_top (
        .clk_sys, .sys_rst, .spr_wr_en, .spr_wr_sel, .spr_wr_data,
        .spr_rd_sel, .spr_rd_data, .timer_clock_pick, .ext_timer_clk,
        .freeze_enable, .debug_event_recorded, .countdown_event,
        .countdown_tick, .ctrl_out, .time_base, .watchdog_irq,
        .countdown_irq, .interval_irq, .wd_reset
    );
    twd_core_model u_twd_core_model (
        .clk_sys, .sys_rst, .watchdog_irq, .wd_reset, .crit_restore,
        .crit_cnt, .resets_seen, .last_kind
    );

    // 200 MHz clock
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask

    // one-cycle write strobe, launched and dropped on falling edges
    task automatic wr(input twd_spr_t s, input logic [31:0] d);
        @(negedge clk_sys);
        spr_wr_en = 1'b1;
        spr_wr_sel = s;
        spr_wr_data = d;
        @(negedge clk_sys);
        spr_wr_en = 1'b0;
    endtask

    // read: the note goes in the queue, the monitor compares later
    task automatic rd(input twd_spr_t s, input logic [31:0] m, e);
        @(negedge clk_sys);
        spr_rd_sel = s;
        mq.push_back(m);
        eq.push_back(e & m);
        rd_pend = 1'b1;
        @(negedge clk_sys);
        rd_pend = 1'b0;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // one rise of the watched bit, by count or by software write
    task automatic rise(input int p);
        logic [63:0] v;
        v = 64'h1 << (WD_BIT_P0 + 4 * p);
        if (nrise % 2 == 1) begin
            wr(SPR_TB_LOW, 32'h0);
            wr(SPR_TB_HIGH, 32'h0);
        end else begin
            v = v - 64'(4 + $urandom % 8);
        end
        wr(SPR_TB_HIGH, v[63:32]);
        wr(SPR_TB_LOW, v[31:0]);
        nrise++;
        wait_n(20);
    endtask

    // result monitor: read data and reset pulses against the notes
    always @(posedge clk_sys) rd_due <= rd_pend;
    always @(negedge clk_sys) begin
        if (rd_due)
            cmp_word(spr_rd_data & mq.pop_front(), eq.pop_front());
        if (wd_reset.req === 1'b1) begin
            if (kq.size() == 0)
                cmp_word(32'h1, 32'h0);
            else
                cmp_word({30'h0, wd_reset.kind}, {30'h0, kq.pop_front()});
        end
    end

    // hang guard
    initial begin
        repeat (40000) @(posedge clk_sys);
        error_cnt++;
        close_out();
    end

    initial begin
        seed_dummy = $urandom(32'h3f83);
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        rd(SPR_CTRL, 32'hffff_ffff, 32'h0);
        rd(SPR_STAT, 32'hffff_ffff, 32'h0);
        // countdown flag set by event, cleared by a one in the mask
        wr(SPR_CTRL, 32'h0400_0000);
        @(negedge clk_sys);
        countdown_event = 1'b1;
        @(negedge clk_sys);
        countdown_event = 1'b0;
        wait_n(2);
        cmp_flag(countdown_irq, 1'b1);
        cmp_flag(countdown_tick, 1'b1);
        rd(SPR_STAT, 32'h0800_0000, 32'h0800_0000);
        wr(SPR_STAT, 32'h0800_0000);
        rd(SPR_STAT, 32'h0800_0000, 32'h0);
        // full watchdog walk on every period and every reset kind
        for (int p = 0; p < 4; p++) begin
            logic [1:0] k;
            logic       irq_on;
            k = (p == 0) ? 2'h1 : 2'(p);
            irq_on = ~p[0];
            wr(SPR_STAT, 32'hffff_ffff);
            @(negedge clk_sys);
            crit_restore = 1'b1;
            @(negedge clk_sys);
            crit_restore = 1'b0;
            wr(SPR_CTRL, {2'(p), k, irq_on, 27'h0});
            rise(p);
            rd(SPR_STAT, 32'hf000_0000, 32'h8000_0000);
            cmp_flag(watchdog_irq, 1'b0);
            rise(p);
            rd(SPR_STAT, 32'hf000_0000, 32'hc000_0000);
            cmp_flag(watchdog_irq, irq_on);
            kq.push_back(k);
            rise(p);
            rd(SPR_STAT, 32'hf000_0000, {2'b11, k, 28'h0});
            rd(SPR_CTRL, 32'h3000_0000, 32'h0);
            wr(SPR_STAT, 32'h8000_0000);
            // first rise only re-arms, second finds no kind left
            repeat (2) begin
                rise(p);
                rd(SPR_STAT, 32'hf000_0000, {2'b11, k, 28'h0});
            end
        end
        cmp_word({24'h0, crit_cnt}, 32'h2);
        cmp_word({24'h0, resets_seen}, 32'h4);
        cmp_word({30'h0, last_kind}, 32'h3);
        // freeze holds a written value; quarter-rate external clock counts
        r = $urandom;
        freeze_enable = 1'b1;
        debug_event_recorded = 1'b1;
        wr(SPR_TB_LOW, r);
        wait_n(6);
        cmp_flag(countdown_tick, 1'b0);
        rd(SPR_TB_LOW, 32'hffff_ffff, r);
        debug_event_recorded = 1'b0;
        wait_n(4);
        freeze_enable = 1'b0;
        timer_clock_pick = 1'b1;
        wait_n(3);
        wr(SPR_TB_LOW, r);
        wait_n(3);
        repeat (4) begin
            ext_timer_clk = 1'b1;
            wait_n(2);
            ext_timer_clk = 1'b0;
            wait_n(2);
        end
        wait_n(3);
        rd(SPR_TB_LOW, 32'hffff_ffff, r + 32'h4);
        timer_clock_pick = 1'b0;
        // reserved bits drop, kind sticks until a processor reset
        wr(SPR_CTRL, 32'hffff_ffff);
        rd(SPR_CTRL, 32'hffff_ffff, 32'hffc0_0000);
        // interval select 11 watches bit 24; only this write can raise it
        wr(SPR_STAT, 32'h0400_0000);
        wr(SPR_TB_LOW, 32'h0);
        wr(SPR_TB_LOW, 32'h0100_0000);
        wait_n(2);
        cmp_flag(interval_irq, 1'b1);
        wr(SPR_CTRL, 32'h0);
        rd(SPR_CTRL, 32'hffff_ffff, 32'h3000_0000);
        @(negedge clk_sys);
        sys_rst = 1'b1;
        wait_n(3);
        sys_rst = 1'b0;
        rd(SPR_CTRL, 32'hffff_ffff, 32'h0);
        rd(SPR_STAT, 32'hffff_ffff, 32'h0);
        wait_n(3);
        cmp_word(32'(kq.size()), 32'h0);
        close_out();
    end
endmodule
